// ### rtl/tlbsel_top.sv
// Translation buffer entry selection: slot select, probe and victim counter
// ==========================================================================
`timescale 1ns/1ps
module tlbsel_top
  import tlbsel_pkg::*;
#(
  parameter bit HAS_TLB_MMU = 1'b1
)(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic [tlbsel_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [tlbsel_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [tlbsel_pkg::DATA_W-1:0] reg_rdata,
  input  wire tlbsel_pkg::tlbsel_op_t        op,
  input  wire logic                          op_other_vpe,
  output logic                               entry_wr_en,
  output logic                               entry_inv_en,
  output logic                               entry_rd_en,
  output logic                               flush_inv_en,
  output logic      [tlbsel_pkg::SLOT_W-1:0] entry_slot,
  output logic      [tlbsel_pkg::VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] entry_virtual_page_pair_number,
  output logic                               probe_done
);
  import tlbsel_pkg::*;

  // ==========================================================================
  // State
  typedef enum logic [2:0] {
    TLBSEL_ST_IDLE  = 3'b001,
    TLBSEL_ST_PROBE = 3'b010,
    TLBSEL_ST_WRITE = 3'b100
  } tlbsel_state_t;

  typedef struct packed {
    tlbsel_state_t                          fsm;
    logic                                   miss;
    logic [SLOT_W-1:0]                      slot;
    logic [SLOT_W-1:0]                      victim;
    logic [SLOT_W-1:0]                      pinned;
    logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0]                      virtual_page_pair_number;
    logic [NUM_ENTRIES-1:0][VIRTUAL_PAGE_PAIR_NUMBER_W-1:0]     tags;
    logic [NUM_ENTRIES-1:0]                 valid;
    logic [DATA_W-1:0]                      rdata;
    logic                                   wr_en;
    logic                                   inv_en;
    logic                                   rd_en;
    logic                                   flush_en;
    logic [SLOT_W-1:0]                      out_slot;
    logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0]                      out_virtual_page_pair_number;
    logic                                   probe_done;
  } tlbsel_st_t;

  tlbsel_st_t st_q;
  tlbsel_st_t st_d;

  logic              lfsr_hold;
  logic              probe_hit;
  logic [SLOT_W-1:0] probe_slot;

  // ==========================================================================
  // Helpers
  function automatic logic [SLOT_W-1:0] next_victim(
    input logic [SLOT_W-1:0] cur,
    input logic [SLOT_W-1:0] floor_slot
  );
    // Wrap at the pinned floor; also recovers if floor was raised above cur
    if (cur <= floor_slot) begin
      return SLOT_MAX;
    end
    return cur - SLOT_W'(1);
  endfunction

  function automatic logic [SLOT_W-1:0] skip_slot(
    input logic [SLOT_W-1:0] cur,
    input logic [SLOT_W-1:0] floor_slot,
    input logic [SLOT_W-1:0] avoid,
    input logic              avoid_en
  );
    if (avoid_en && (cur == avoid)) begin
      return next_victim(cur, floor_slot);
    end
    return cur;
  endfunction

  // One clock of the victim counter; a floor raised above the count forces a wrap
  function automatic logic [SLOT_W-1:0] victim_step(
    input logic [SLOT_W-1:0] cur,
    input logic [SLOT_W-1:0] floor_slot,
    input logic              hold
  );
    if (!hold) begin
      return next_victim(cur, floor_slot);
    end
    if (cur < floor_slot) begin
      return SLOT_MAX;
    end
    return cur;
  endfunction

  // ==========================================================================
  // Register port helpers
  // Upper bits are dropped so a careless write cannot leave the slot range
  function automatic logic [SLOT_W-1:0] slot_field(
    input logic [DATA_W-1:0] word
  );
    return word[SLOT_W-1:0];
  endfunction

  function automatic logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] virtual_page_pair_number_field(
    input logic [DATA_W-1:0] word
  );
    return word[VIRTUAL_PAGE_PAIR_NUMBER_MSB:VIRTUAL_PAGE_PAIR_NUMBER_LSB];
  endfunction

  // Port is dead when a protection unit replaces the translation buffer
  function automatic logic reg_live(
    input logic strobe
  );
    return strobe && HAS_TLB_MMU;
  endfunction

  // Read word assembly; every unused bit stays zero
  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] addr,
    input logic              miss,
    input logic [SLOT_W-1:0] slot,
    input logic [SLOT_W-1:0] victim,
    input logic [SLOT_W-1:0] pinned,
    input logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] virtual_page_pair_number
  );
    logic [DATA_W-1:0] word;
    word = '0;
    case (addr)
      OFS_SLOT_SELECT: begin
        word[MISS_BIT]   = miss;
        word[SLOT_W-1:0] = slot;
      end
      OFS_VICTIM_SLOT: begin
        word[SLOT_W-1:0] = victim;
      end
      OFS_PINNED_COUNT: begin
        word[SLOT_W-1:0] = pinned;
      end
      OFS_ENTRY_HIGH: begin
        word[VIRTUAL_PAGE_PAIR_NUMBER_MSB:VIRTUAL_PAGE_PAIR_NUMBER_LSB] = virtual_page_pair_number;
      end
      default: begin
      end
    endcase
    return word;
  endfunction

  // ==========================================================================
  // Submodules
  tlbsel_lfsr u_lfsr (
    .clk   (clk),
    .reset (reset),
    .hold  (lfsr_hold)
  );

  tlbsel_match u_match (
    .key   (st_q.virtual_page_pair_number),
    .tags  (st_q.tags),
    .valid (st_q.valid),
    .hit   (probe_hit),
    .slot  (probe_slot)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    logic [SLOT_W-1:0] rnd_slot;
    logic              buf_write;
    st_d            = st_q;
    rnd_slot        = '0;
    buf_write       = 1'b0;
    st_d.wr_en      = 1'b0;
    st_d.inv_en     = 1'b0;
    st_d.rd_en      = 1'b0;
    st_d.flush_en   = 1'b0;
    st_d.probe_done = 1'b0;

    // Free-running victim counter, held back on LFSR cycles
    st_d.victim = victim_step(st_q.victim, st_q.pinned, lfsr_hold);

    case (st_q.fsm)
      TLBSEL_ST_IDLE: begin
        case (op)
          TLBSEL_OP_ENTRY_READ: begin
            st_d.rd_en    = 1'b1;
            st_d.out_slot = st_q.slot;
            st_d.out_virtual_page_pair_number = st_q.tags[st_q.slot];
          end
          TLBSEL_OP_INDEXED_WR: begin
            st_d.wr_en             = 1'b1;
            st_d.out_slot          = st_q.slot;
            st_d.out_virtual_page_pair_number          = st_q.virtual_page_pair_number;
            st_d.tags[st_q.slot]   = st_q.virtual_page_pair_number;
            st_d.valid[st_q.slot]  = 1'b1;
            buf_write              = 1'b1;
          end
          TLBSEL_OP_RANDOM_WR: begin
            rnd_slot = skip_slot(st_q.victim, st_q.pinned, st_q.slot,
                                 st_q.miss & op_other_vpe);
            st_d.wr_en            = 1'b1;
            st_d.out_slot         = rnd_slot;
            st_d.out_virtual_page_pair_number         = st_q.virtual_page_pair_number;
            st_d.tags[rnd_slot]   = st_q.virtual_page_pair_number;
            st_d.valid[rnd_slot]  = 1'b1;
            buf_write             = 1'b1;
          end
          TLBSEL_OP_PROBE: begin
            st_d.fsm = TLBSEL_ST_PROBE;
          end
          TLBSEL_OP_ENTRY_INV: begin
            st_d.inv_en            = 1'b1;
            st_d.out_slot          = st_q.slot;
            st_d.valid[st_q.slot]  = 1'b0;
            buf_write              = 1'b1;
          end
          TLBSEL_OP_FLUSH_INV: begin
            st_d.flush_en = 1'b1;
            st_d.out_slot = st_q.slot;
            st_d.valid    = '0;
            buf_write     = 1'b1;
          end
          default: begin
          end
        endcase
      end
      TLBSEL_ST_PROBE: begin
        // Compare runs on registered state so a same-cycle edit cannot race it
        st_d.probe_done = 1'b1;
        if (probe_hit) begin
          st_d.slot = probe_slot;
          st_d.miss = 1'b0;
        end else begin
          st_d.miss = 1'b1;
        end
        st_d.fsm = TLBSEL_ST_IDLE;
      end
      TLBSEL_ST_WRITE: begin
        st_d.fsm = TLBSEL_ST_IDLE;
      end
      default: begin
        st_d.fsm = TLBSEL_ST_IDLE;
      end
    endcase

    if (buf_write) begin
      st_d.victim = SLOT_MAX;
    end

    // Register writes; the hardware probe result wins over a software write
    if (reg_live(reg_wr)) begin
      case (reg_addr)
        OFS_SLOT_SELECT: begin
          if (st_q.fsm != TLBSEL_ST_PROBE) begin
            st_d.slot = slot_field(reg_wdata);
            st_d.miss = reg_wdata[MISS_BIT];
          end
        end
        OFS_PINNED_COUNT: begin
          st_d.pinned = slot_field(reg_wdata);
          st_d.victim = SLOT_MAX;
        end
        OFS_ENTRY_HIGH: begin
          st_d.virtual_page_pair_number = virtual_page_pair_number_field(reg_wdata);
        end
        default: begin
        end
      endcase
    end

    st_d.rdata = '0;
    if (reg_live(reg_rd)) begin
      st_d.rdata = read_word(reg_addr, st_q.miss, st_q.slot, st_q.victim, st_q.pinned,
                             st_q.virtual_page_pair_number);
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q.fsm        <= TLBSEL_ST_IDLE;
      st_q.miss       <= 1'b0;
      st_q.slot       <= '0;
      st_q.victim     <= SLOT_MAX;
      st_q.pinned     <= PINNED_RESET;
      st_q.virtual_page_pair_number       <= '0;
      st_q.tags       <= '0;
      st_q.valid      <= '0;
      st_q.rdata      <= '0;
      st_q.wr_en      <= 1'b0;
      st_q.inv_en     <= 1'b0;
      st_q.rd_en      <= 1'b0;
      st_q.flush_en   <= 1'b0;
      st_q.out_slot   <= '0;
      st_q.out_virtual_page_pair_number   <= '0;
      st_q.probe_done <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata    = st_q.rdata;
  assign entry_wr_en  = st_q.wr_en;
  assign entry_inv_en = st_q.inv_en;
  assign entry_rd_en  = st_q.rd_en;
  assign flush_inv_en = st_q.flush_en;
  assign entry_slot   = st_q.out_slot;
  assign entry_virtual_page_pair_number   = st_q.out_virtual_page_pair_number;
  assign probe_done   = st_q.probe_done;
endmodule

// ### rtl/tlbsel_pkg.sv
// Shared constants for the translation buffer entry selection block
package tlbsel_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned SLOT_W      = 6;
  localparam int unsigned NUM_ENTRIES = 64;
  localparam int unsigned VIRTUAL_PAGE_PAIR_NUMBER_W      = 19;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned LFSR_W      = 16;

  // ==========================================================================
  // Register offsets (word addresses on the local register port)
  localparam logic [ADDR_W-1:0] OFS_SLOT_SELECT  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_VICTIM_SLOT  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PINNED_COUNT = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_ENTRY_HIGH   = 4'h3;

  // ==========================================================================
  // Field positions
  localparam int unsigned MISS_BIT  = 31;
  localparam int unsigned VIRTUAL_PAGE_PAIR_NUMBER_LSB  = 13;
  localparam int unsigned VIRTUAL_PAGE_PAIR_NUMBER_MSB  = 31;

  // ==========================================================================
  // Reset values and LFSR taps
  localparam logic [SLOT_W-1:0] SLOT_MAX      = 6'h3f;
  localparam logic [SLOT_W-1:0] PINNED_RESET  = 6'h00;
  localparam logic [LFSR_W-1:0] LFSR_SEED     = 16'hace1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS     = 16'hb400;

  // ==========================================================================
  // Pipeline operations
  typedef enum logic [2:0] {
    TLBSEL_OP_NONE        = 3'h0,
    TLBSEL_OP_ENTRY_READ  = 3'h1,
    TLBSEL_OP_INDEXED_WR  = 3'h2,
    TLBSEL_OP_RANDOM_WR   = 3'h3,
    TLBSEL_OP_PROBE       = 3'h4,
    TLBSEL_OP_ENTRY_INV   = 3'h5,
    TLBSEL_OP_FLUSH_INV   = 3'h6
  } tlbsel_op_t;

endpackage

// ### rtl/tlbsel_lfsr.sv
// Pseudo-random hold generator for the victim counter
`timescale 1ns/1ps
module tlbsel_lfsr
  import tlbsel_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  output logic      hold
);
  typedef struct packed {
    logic [tlbsel_pkg::LFSR_W-1:0] sr;
  } tlbsel_lfsr_st_t;

  tlbsel_lfsr_st_t st_q;
  tlbsel_lfsr_st_t st_d;

  // Galois form; the two low bits together decide a hold cycle
  always_comb begin
    st_d = st_q;
    if (st_q.sr[0]) begin
      st_d.sr = (st_q.sr >> 1) ^ LFSR_TAPS;
    end else begin
      st_d.sr = st_q.sr >> 1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q.sr <= LFSR_SEED;
    end else begin
      st_q <= st_d;
    end
  end

  // Hold on roughly one cycle in four so the counter still moves most clocks
  assign hold = st_q.sr[0] & st_q.sr[1];
endmodule

// ### rtl/tlbsel_match.sv
// Parallel tag comparison for the probe operation
`timescale 1ns/1ps
module tlbsel_match
  import tlbsel_pkg::*;
(
  input  wire logic [tlbsel_pkg::VIRTUAL_PAGE_PAIR_NUMBER_W-1:0]                        key,
  input  wire logic [tlbsel_pkg::NUM_ENTRIES-1:0][tlbsel_pkg::VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] tags,
  input  wire logic [tlbsel_pkg::NUM_ENTRIES-1:0]                   valid,
  output logic                                                      hit,
  output logic [tlbsel_pkg::SLOT_W-1:0]                             slot
);
  // Lowest matching slot wins if software ever built duplicates
  always_comb begin
    hit  = 1'b0;
    slot = '0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
      if (valid[i] && (tags[i] == key)) begin
        hit  = 1'b1;
        slot = SLOT_W'(i);
      end
    end
  end
endmodule

// ### verif/tlbsel_pipe_model.sv
// Pipeline stand-in that issues entry selection operations
`timescale 1ns/1ps
module tlbsel_pipe_model (
  input  wire logic              clk,
  output tlbsel_pkg::tlbsel_op_t op,
  output logic                   op_other_vpe
);
  import tlbsel_pkg::*;
  initial begin
    op = TLBSEL_OP_NONE;
    op_other_vpe = 1'b0;
  end
  // ==========================================================================
  // Issue
  // The source flag flips once the op is gone, so a stale level is never trusted
  task automatic issue(input tlbsel_op_t o, input logic oth);
    op <= o;
    op_other_vpe <= oth;
    @(posedge clk);
    op <= TLBSEL_OP_NONE;
    op_other_vpe <= ~oth;
  endtask
endmodule

// ### verif/tlbsel_assertions.sv
// Concurrent checks on the entry selection ports
`timescale 1ns/1ps
module tlbsel_checker (
  input wire logic                          clk,
  input wire logic                          reset,
  input wire logic [tlbsel_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tlbsel_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [tlbsel_pkg::DATA_W-1:0] reg_rdata,
  input wire tlbsel_pkg::tlbsel_op_t        op,
  input wire logic                          op_other_vpe,
  input wire logic                          entry_wr_en,
  input wire logic                          entry_inv_en,
  input wire logic                          entry_rd_en,
  input wire logic                          flush_inv_en,
  input wire logic [tlbsel_pkg::SLOT_W-1:0] entry_slot,
  input wire logic [tlbsel_pkg::VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] entry_virtual_page_pair_number,
  input wire logic                          probe_done
);
  import tlbsel_pkg::*;
  logic [SLOT_W-1:0] pin_q;
  always_ff @(posedge clk) begin
    if (reset)
      pin_q <= '0;
    else if (reg_wr && reg_addr == OFS_PINNED_COUNT)
      pin_q <= reg_wdata[SLOT_W-1:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_read_source:
    assert property (entry_rd_en |-> $past(op) == TLBSEL_OP_ENTRY_READ) else $error("stray read");
  chk_inv_source:
    assert property (entry_inv_en |-> $past(op) == TLBSEL_OP_ENTRY_INV) else $error("stray inval");
  chk_flush_source:
    assert property (flush_inv_en |-> $past(op) == TLBSEL_OP_FLUSH_INV) else $error("stray flush");
  chk_write_cause:
    assert property (op == TLBSEL_OP_INDEXED_WR && $past(op) != TLBSEL_OP_PROBE |=> entry_wr_en)
      else $error("indexed write lost");
  chk_probe_answer:
    assert property (op == TLBSEL_OP_PROBE && $past(op) != TLBSEL_OP_PROBE |-> ##2 probe_done)
      else $error("probe result missing");
  chk_done_cause:
    assert property (probe_done |-> $past(op, 2) == TLBSEL_OP_PROBE) else $error("stray probe");
  chk_random_floor:
    assert property (op == TLBSEL_OP_RANDOM_WR && $past(op) != TLBSEL_OP_PROBE
      |=> entry_wr_en && entry_slot >= pin_q) else $error("random write below floor");
  chk_victim_range:
    assert property ($past(reg_rd) && $past(reg_addr) == OFS_VICTIM_SLOT
      |-> reg_rdata[31:6] == '0 && reg_rdata[5:0] >= pin_q) else $error("victim out of range");
  chk_slot_zeros:
    assert property ($past(reg_rd) && $past(reg_addr) == OFS_SLOT_SELECT
      |-> reg_rdata[30:6] == '0) else $error("slot select upper bits");
endmodule
bind tlbsel_top tlbsel_checker u_tlbsel_checker (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op(op),
  .op_other_vpe(op_other_vpe), .entry_wr_en(entry_wr_en), .entry_inv_en(entry_inv_en),
  .entry_rd_en(entry_rd_en), .flush_inv_en(flush_inv_en), .entry_slot(entry_slot),
  .entry_virtual_page_pair_number(entry_virtual_page_pair_number), .probe_done(probe_done));

// ### verif/tlbsel_top_tb.sv
// Self-checking bench for the entry selection block
`timescale 1ns/1ps
module tlbsel_top_tb;
  import tlbsel_pkg::*;
  localparam logic [DATA_W-1:0] EH = 32'habcd_e000;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata, d;
  tlbsel_op_t        op;
  logic              op_other_vpe, entry_wr_en, entry_inv_en, entry_rd_en, flush_inv_en, pd;
  logic              probe_done;
  logic [SLOT_W-1:0] entry_slot;
  logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] entry_virtual_page_pair_number;
  logic [3:0]        en;
  logic [SLOT_W-1:0] v [32];
  logic [ADDR_W-1:0] ra [4] = '{OFS_SLOT_SELECT, OFS_ENTRY_HIGH, OFS_PINNED_COUNT, 4'hf};
  logic [DATA_W-1:0] re [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  tlbsel_op_t        ops [4] = '{TLBSEL_OP_ENTRY_READ, TLBSEL_OP_INDEXED_WR,
                                 TLBSEL_OP_ENTRY_INV, TLBSEL_OP_FLUSH_INV};
  int                n_errors = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  int                holds, decs;
  always #5 clk = ~clk;
  tlbsel_top u_tlbsel_top (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op(op), .op_other_vpe(op_other_vpe),
    .entry_wr_en(entry_wr_en), .entry_inv_en(entry_inv_en), .entry_rd_en(entry_rd_en),
    .flush_inv_en(flush_inv_en), .entry_slot(entry_slot), .entry_virtual_page_pair_number(entry_virtual_page_pair_number),
    .probe_done(probe_done));
  tlbsel_pipe_model u_pipe (.clk(clk), .op(op), .op_other_vpe(op_other_vpe));
  // ==========================================================================
  // Tasks
  task automatic cmp32(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    cmp32({31'h0, g}, {31'h0, e});
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 x = reg_rdata;
    @(posedge clk);
  endtask
  // Optional victim read lands in the cycle right after the op, before any decrement
  task automatic do_op(input tlbsel_op_t o, input logic oth, input logic rv);
    u_pipe.issue(o, oth);
    if (rv) begin
      reg_addr <= OFS_VICTIM_SLOT;
      reg_rd <= 1'b1;
    end
    #1 en = {entry_rd_en, entry_wr_en, entry_inv_en, flush_inv_en};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    pd = probe_done;
    @(posedge clk);
  endtask
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end
  // ==========================================================================
  // Tests
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    // Read on the release edge itself, before the counter can move off its reset value
    rd(OFS_VICTIM_SLOT, d);
    cmp32(d, 32'h0000_003f);
    for (int i = 0; i < 4; i++) begin
      rd(ra[i], d);
      cmp32(d, re[i]);
    end
    $display("test reset done");
    wr(OFS_ENTRY_HIGH, EH);
    wr(OFS_SLOT_SELECT, 32'h0000_0007);
    do_op(TLBSEL_OP_INDEXED_WR, 1'b0, 1'b0);
    cmp32({26'h0, entry_slot}, 32'h0000_0007);
    cmp32({13'h0, entry_virtual_page_pair_number}, {13'h0, EH[31:13]});
    wr(OFS_SLOT_SELECT, 32'h8000_0003);
    do_op(TLBSEL_OP_PROBE, 1'b0, 1'b0);
    cmp1(pd, 1'b1);
    rd(OFS_SLOT_SELECT, d);
    cmp32(d, 32'h0000_0007);
    wr(OFS_ENTRY_HIGH, 32'h1234_4000);
    do_op(TLBSEL_OP_PROBE, 1'b0, 1'b0);
    rd(OFS_SLOT_SELECT, d);
    cmp32(d & 32'hffff_ffc0, 32'h8000_0000);
    $display("test probe done");
    wr(OFS_SLOT_SELECT, 32'h0000_0005);
    for (int i = 0; i < 4; i++) begin
      do_op(ops[i], 1'b0, 1'b0);
      cmp32({28'h0, en}, {28'h0, 4'b1000 >> i});
      cmp32({26'h0, entry_slot}, 32'h0000_0005);
    end
    $display("test indexed done");
    wr(OFS_PINNED_COUNT, 32'h0000_003e);
    wr(OFS_SLOT_SELECT, 32'h8000_003f);
    repeat (4) begin
      do_op(TLBSEL_OP_RANDOM_WR, 1'b1, 1'b0);
      cmp32({26'h0, entry_slot}, 32'h0000_003e);
    end
    do_op(TLBSEL_OP_RANDOM_WR, 1'b0, 1'b1);
    cmp1(en[2] && entry_slot >= 6'h3e, 1'b1);
    cmp32(d, 32'h0000_003f);
    $display("test random done");
    reg_addr <= OFS_PINNED_COUNT;
    reg_wdata <= 32'h0000_003c;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= OFS_VICTIM_SLOT;
    reg_rd <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      if (i == 31)
        reg_rd <= 1'b0;
      #1 v[i] = reg_rdata[SLOT_W-1:0];
    end
    @(posedge clk);
    cmp32({26'h0, v[0]}, 32'h0000_003f);
    holds = 0;
    decs = 0;
    for (int i = 1; i < 32; i++) begin
      holds += (v[i] == v[i-1]);
      decs += (v[i] == v[i-1] - 6'h1);
      cmp1(v[i] >= 6'h3c && (v[i] == v[i-1] || v[i] == v[i-1] - 6'h1 ||
           (v[i-1] == 6'h3c && v[i] == 6'h3f)), 1'b1);
    end
    cmp1(holds > 0 && decs > 0, 1'b1);
    $display("test victim done");
    summarize();
  end
endmodule
